/* hdl/pbr_pkg.sv */
// pbr_pkg: constants and carrier types for the per-port basic control/status registers.
// assumes one switch core clock; used by pbr_regs and pbr_port.
package pbr_pkg;
  localparam int NUM_PORTS = 2;
  localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
  localparam logic [4:0] PHYAD_PORT1_DEFAULT = 5'h01;
  localparam logic [4:0] PHYAD_PORT2_DEFAULT = 5'h02;
  // basic control field positions
  localparam int CTL_LOOPBACK = 14;
  localparam int CTL_FORCE_100 = 13;
  localparam int CTL_AUTONEG_ENABLE = 12;
  localparam int CTL_POWER_DOWN = 11;
  localparam int CTL_AUTONEG_RESTART = 9;
  localparam int CTL_FORCE_FULL = 8;
  localparam int CTL_CROSSOVER_VARIANT = 5;
  localparam int CTL_FORCE_STRAIGHT = 4;
  localparam int CTL_DISABLE_CROSSOVER = 3;
  localparam int CTL_DISABLE_FAR_END = 2;
  localparam int CTL_DISABLE_TX = 1;
  localparam int CTL_DISABLE_LED = 0;
  // basic status field positions
  localparam int STS_AUTONEG_DONE = 5;
  localparam int STS_FAR_END_FAULT = 4;
  localparam int STS_AUTONEG_ABLE = 3;
  localparam int STS_LINK_UP = 2;
  localparam logic [15:0] STS_CAPABILITY_BITS = 16'h7800;
  // switch-side register bit positions (8-bit registers)
  localparam int SW_CTL_A_FORCE_100 = 6;
  localparam int SW_CTL_A_AUTONEG_ENABLE = 7;
  localparam int SW_CTL_A_FORCE_FULL = 5;
  localparam int SW_CTL_B_LOOPBACK = 0;
  localparam int SW_CTL_B_FORCE_STRAIGHT = 1;
  localparam int SW_CTL_B_DISABLE_CROSSOVER = 2;
  localparam int SW_CTL_B_POWER_DOWN = 3;
  localparam int SW_CTL_B_DISABLE_FAR_END = 4;
  localparam int SW_CTL_B_AUTONEG_RESTART = 5;
  localparam int SW_CTL_B_DISABLE_TX = 6;
  localparam int SW_CTL_B_DISABLE_LED = 7;
  localparam int SW_STS_LINK_UP = 5;
  localparam int SW_STS_AUTONEG_DONE = 6;
  localparam int SW_STS_C_CROSSOVER_VARIANT = 7;
  localparam int SW_STS_C_FAR_END_FAULT = 0;

  typedef struct packed {
    logic loopback;
    logic force_100;
    logic autoneg_enable;
    logic power_down;
    logic autoneg_restart;
    logic force_full;
    logic crossover_variant_select;
    logic force_straight_through;
    logic disable_crossover;
    logic disable_far_end;
    logic disable_tx;
    logic disable_led;
  } pbr_ctl_type;

  localparam pbr_ctl_type CTL_RESET = '{
    loopback: 1'b0, force_100: 1'b0, autoneg_enable: 1'b1, power_down: 1'b0,
    autoneg_restart: 1'b0, force_full: 1'b0, crossover_variant_select: 1'b1,
    force_straight_through: 1'b0, disable_crossover: 1'b0, disable_far_end: 1'b0,
    disable_tx: 1'b0, disable_led: 1'b0};

  typedef struct packed {
    logic autoneg_done;
    logic far_end_fault;
    logic link_up;
  } pbr_phy_sts_type;

  // write request from one access path
  typedef struct packed {
    logic wr;
    logic [4:0] sel;
    logic [15:0] data;
  } pbr_wr_type;

  // switch-side per-port view of the shared fields
  typedef struct packed {
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic [7:0] sts_c;
  } pbr_sw_view_type;
endpackage : pbr_pkg

/* hdl/pbr_port.sv */
// pbr_port: one port's shared control storage and status view.
// assumes status inputs are already synchronous to clk_sys.
`timescale 1ns/100ps
module pbr_port (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic mii_wr,
  input wire logic [15:0] mii_wdata,
  input wire logic sw_wr_a,
  input wire logic sw_wr_b,
  input wire logic sw_wr_c,
  input wire logic [7:0] sw_wdata,
  input wire pbr_pkg::pbr_phy_sts_type phy_sts,
  output pbr_pkg::pbr_ctl_type ctl,
  output logic [15:0] basic_control,
  output logic [15:0] basic_status,
  output pbr_pkg::pbr_sw_view_type sw_view
);
  typedef struct packed {
    pbr_pkg::pbr_ctl_type ctl;
  } pbr_port_state_type;

  pbr_port_state_type state_reg;
  pbr_port_state_type state_next;

  always_comb begin
    state_next = state_reg;
    if (mii_wr) begin
      // unsupported bits 15,10,7,6 are simply not stored
      state_next.ctl.loopback = mii_wdata[pbr_pkg::CTL_LOOPBACK];
      state_next.ctl.force_100 = mii_wdata[pbr_pkg::CTL_FORCE_100];
      state_next.ctl.autoneg_enable = mii_wdata[pbr_pkg::CTL_AUTONEG_ENABLE];
      state_next.ctl.power_down = mii_wdata[pbr_pkg::CTL_POWER_DOWN];
      state_next.ctl.autoneg_restart = mii_wdata[pbr_pkg::CTL_AUTONEG_RESTART];
      state_next.ctl.force_full = mii_wdata[pbr_pkg::CTL_FORCE_FULL];
      state_next.ctl.crossover_variant_select =
        mii_wdata[pbr_pkg::CTL_CROSSOVER_VARIANT];
      state_next.ctl.force_straight_through = mii_wdata[pbr_pkg::CTL_FORCE_STRAIGHT];
      state_next.ctl.disable_crossover = mii_wdata[pbr_pkg::CTL_DISABLE_CROSSOVER];
      state_next.ctl.disable_far_end = mii_wdata[pbr_pkg::CTL_DISABLE_FAR_END];
      state_next.ctl.disable_tx = mii_wdata[pbr_pkg::CTL_DISABLE_TX];
      state_next.ctl.disable_led = mii_wdata[pbr_pkg::CTL_DISABLE_LED];
    end
    // switch-side write lands in the same flops; applied last so it wins a tie
    if (sw_wr_a) begin
      state_next.ctl.force_100 = sw_wdata[pbr_pkg::SW_CTL_A_FORCE_100];
      state_next.ctl.autoneg_enable = sw_wdata[pbr_pkg::SW_CTL_A_AUTONEG_ENABLE];
      state_next.ctl.force_full = sw_wdata[pbr_pkg::SW_CTL_A_FORCE_FULL];
    end
    if (sw_wr_b) begin
      state_next.ctl.loopback = sw_wdata[pbr_pkg::SW_CTL_B_LOOPBACK];
      state_next.ctl.force_straight_through = sw_wdata[pbr_pkg::SW_CTL_B_FORCE_STRAIGHT];
      state_next.ctl.disable_crossover = sw_wdata[pbr_pkg::SW_CTL_B_DISABLE_CROSSOVER];
      state_next.ctl.power_down = sw_wdata[pbr_pkg::SW_CTL_B_POWER_DOWN];
      state_next.ctl.disable_far_end = sw_wdata[pbr_pkg::SW_CTL_B_DISABLE_FAR_END];
      state_next.ctl.autoneg_restart = sw_wdata[pbr_pkg::SW_CTL_B_AUTONEG_RESTART];
      state_next.ctl.disable_tx = sw_wdata[pbr_pkg::SW_CTL_B_DISABLE_TX];
      state_next.ctl.disable_led = sw_wdata[pbr_pkg::SW_CTL_B_DISABLE_LED];
    end
    if (sw_wr_c) begin
      state_next.ctl.crossover_variant_select = sw_wdata[pbr_pkg::SW_STS_C_CROSSOVER_VARIANT];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '{ctl: pbr_pkg::CTL_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign ctl = state_reg.ctl;

  always_comb begin
    basic_control = 16'h0000;
    basic_control[pbr_pkg::CTL_LOOPBACK] = state_reg.ctl.loopback;
    basic_control[pbr_pkg::CTL_FORCE_100] = state_reg.ctl.force_100;
    basic_control[pbr_pkg::CTL_AUTONEG_ENABLE] = state_reg.ctl.autoneg_enable;
    basic_control[pbr_pkg::CTL_POWER_DOWN] = state_reg.ctl.power_down;
    basic_control[pbr_pkg::CTL_AUTONEG_RESTART] = state_reg.ctl.autoneg_restart;
    basic_control[pbr_pkg::CTL_FORCE_FULL] = state_reg.ctl.force_full;
    basic_control[pbr_pkg::CTL_CROSSOVER_VARIANT] = state_reg.ctl.crossover_variant_select;
    basic_control[pbr_pkg::CTL_FORCE_STRAIGHT] = state_reg.ctl.force_straight_through;
    basic_control[pbr_pkg::CTL_DISABLE_CROSSOVER] = state_reg.ctl.disable_crossover;
    basic_control[pbr_pkg::CTL_DISABLE_FAR_END] = state_reg.ctl.disable_far_end;
    basic_control[pbr_pkg::CTL_DISABLE_TX] = state_reg.ctl.disable_tx;
    basic_control[pbr_pkg::CTL_DISABLE_LED] = state_reg.ctl.disable_led;
  end

  always_comb begin
    basic_status = pbr_pkg::STS_CAPABILITY_BITS;
    basic_status[pbr_pkg::STS_AUTONEG_DONE] = phy_sts.autoneg_done;
    basic_status[pbr_pkg::STS_FAR_END_FAULT] = phy_sts.far_end_fault;
    basic_status[pbr_pkg::STS_AUTONEG_ABLE] = state_reg.ctl.autoneg_enable;
    basic_status[pbr_pkg::STS_LINK_UP] = phy_sts.link_up;
  end

  always_comb begin
    sw_view = '0;
    sw_view.ctl_a[pbr_pkg::SW_CTL_A_FORCE_100] = state_reg.ctl.force_100;
    sw_view.ctl_a[pbr_pkg::SW_CTL_A_AUTONEG_ENABLE] = state_reg.ctl.autoneg_enable;
    sw_view.ctl_a[pbr_pkg::SW_CTL_A_FORCE_FULL] = state_reg.ctl.force_full;
    sw_view.ctl_b[pbr_pkg::SW_CTL_B_LOOPBACK] = state_reg.ctl.loopback;
    sw_view.ctl_b[pbr_pkg::SW_CTL_B_FORCE_STRAIGHT] = state_reg.ctl.force_straight_through;
    sw_view.ctl_b[pbr_pkg::SW_CTL_B_DISABLE_CROSSOVER] = state_reg.ctl.disable_crossover;
    sw_view.ctl_b[pbr_pkg::SW_CTL_B_POWER_DOWN] = state_reg.ctl.power_down;
    sw_view.ctl_b[pbr_pkg::SW_CTL_B_DISABLE_FAR_END] = state_reg.ctl.disable_far_end;
    sw_view.ctl_b[pbr_pkg::SW_CTL_B_AUTONEG_RESTART] = state_reg.ctl.autoneg_restart;
    sw_view.ctl_b[pbr_pkg::SW_CTL_B_DISABLE_TX] = state_reg.ctl.disable_tx;
    sw_view.ctl_b[pbr_pkg::SW_CTL_B_DISABLE_LED] = state_reg.ctl.disable_led;
    sw_view.sts_c[pbr_pkg::SW_STS_C_CROSSOVER_VARIANT] = state_reg.ctl.crossover_variant_select;
    sw_view.sts_c[pbr_pkg::SW_STS_C_FAR_END_FAULT] = phy_sts.far_end_fault;
    sw_view.sts_c[pbr_pkg::SW_STS_AUTONEG_DONE] = phy_sts.autoneg_done;
    sw_view.sts_c[pbr_pkg::SW_STS_LINK_UP] = phy_sts.link_up;
  end
endmodule : pbr_port

/* hdl/pbr_regs.sv */
// pbr_regs: basic control/status register pair for both copper ports.
// assumes a management frame engine decodes phy/reg address and gives one-cycle strobes,
// and the switch-side host port map gives 8-bit register strobes; one clock throughout.
//
// Functional notes
// - port-1 loopback wraps port 2 traffic
// - port-2 loopback wraps port 1 traffic
// - bit 13 forces 100 or 10 Mbps
// - bit 12 enables auto-negotiation, resets one
// - bit 11 powers the transceiver down
// - bit 9 restarts auto-negotiation
// - bit 8 forces full or half duplex
// - bit 4 forces straight-through transmit pins
// - bit 3 disables automatic crossover
// - bit 2 disables far-end fault detection
// - bit 1 disables the transmitter
// - bit 0 turns the LEDs off
// - status bits 14..11 always read one
// - status bits 15 and 0 read zero
// - status bit 5 shows negotiation done
// - status bit 4 shows far-end fault
// - status bit 3 follows autoneg enable
// - status bits 10..6 and 1 read zero
// - default phy addresses one and two, reprogrammable
// - host ports reach fields via separate map
`timescale 1ns/100ps
module pbr_regs #(
  parameter logic [4:0] PHYAD_PORT1 = pbr_pkg::PHYAD_PORT1_DEFAULT,
  parameter logic [4:0] PHYAD_PORT2 = pbr_pkg::PHYAD_PORT2_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic phyad_prog_en,
  input wire logic [4:0] phyad_prog,
  input wire logic mii_rd,
  input wire logic mii_wr,
  input wire logic [4:0] mii_phyad,
  input wire logic [4:0] mii_regad,
  input wire logic [15:0] mii_wdata,
  output logic [15:0] mii_rdata,
  output logic mii_rvalid,
  input wire logic [1:0] sw_wr_a,
  input wire logic [1:0] sw_wr_b,
  input wire logic [1:0] sw_wr_c,
  input wire logic [7:0] sw_wdata,
  output pbr_pkg::pbr_sw_view_type [1:0] sw_view,
  input wire pbr_pkg::pbr_phy_sts_type [1:0] phy_sts_async,
  output pbr_pkg::pbr_ctl_type [1:0] port_ctl,
  output logic [1:0] p1_tx_from_p2_rx,
  output logic [1:0] p2_tx_from_p1_rx
);
  typedef struct packed {
    pbr_pkg::pbr_phy_sts_type [1:0] sts_meta;
    pbr_pkg::pbr_phy_sts_type [1:0] sts_sync;
    logic [15:0] rdata;
    logic rvalid;
    pbr_pkg::pbr_sw_view_type [1:0] sw_view;
    pbr_pkg::pbr_ctl_type [1:0] ctl;
    logic loop_p2_path;
    logic loop_p1_path;
  } pbr_top_state_type;

  pbr_top_state_type state_reg;
  pbr_top_state_type state_next;

  logic [1:0] hit;
  logic [1:0] mii_wr_port;
  logic [15:0] bctl [1:0];
  logic [15:0] bsts [1:0];
  pbr_pkg::pbr_ctl_type [1:0] ctl_w;
  pbr_pkg::pbr_sw_view_type [1:0] view_w;
  logic [4:0] addr1;
  logic [4:0] addr2;

  // phy addresses: defaults or the global programmed base and base+1
  assign addr1 = phyad_prog_en ? phyad_prog : PHYAD_PORT1;
  assign addr2 = phyad_prog_en ? 5'(phyad_prog + 5'h01) : PHYAD_PORT2;
  assign hit[0] = (mii_phyad == addr1);
  assign hit[1] = (mii_phyad == addr2);

  genvar gi;
  generate
    for (gi = 0; gi < pbr_pkg::NUM_PORTS; gi++) begin : g_port
      assign mii_wr_port[gi] = mii_wr && hit[gi] && (mii_regad == pbr_pkg::REG_BASIC_CONTROL);
      pbr_port u_port (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .mii_wr(mii_wr_port[gi]),
        .mii_wdata(mii_wdata),
        .sw_wr_a(sw_wr_a[gi]),
        .sw_wr_b(sw_wr_b[gi]),
        .sw_wr_c(sw_wr_c[gi]),
        .sw_wdata(sw_wdata),
        .phy_sts(state_reg.sts_sync[gi]),
        .ctl(ctl_w[gi]),
        .basic_control(bctl[gi]),
        .basic_status(bsts[gi]),
        .sw_view(view_w[gi])
      );
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    // status pins come from the analog side: two flops before use
    state_next.sts_meta = phy_sts_async;
    state_next.sts_sync = state_reg.sts_meta;
    state_next.rvalid = mii_rd;
    if (mii_rd) begin
      // unknown address or register reads zero
      state_next.rdata = 16'h0000;
      for (int i = 0; i < pbr_pkg::NUM_PORTS; i++) begin
        if (hit[i] && mii_regad == pbr_pkg::REG_BASIC_CONTROL) begin
          state_next.rdata = bctl[i];
        end else if (hit[i] && mii_regad == pbr_pkg::REG_BASIC_STATUS) begin
          state_next.rdata = bsts[i];
        end
      end
    end
    state_next.sw_view = view_w;
    state_next.ctl = ctl_w;
    // loopback only wraps at the port's own medium layers, not while powered down
    state_next.loop_p1_path = ctl_w[0].loopback && !ctl_w[0].power_down;
    state_next.loop_p2_path = ctl_w[1].loopback && !ctl_w[1].power_down;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '{default: '0, ctl: {pbr_pkg::CTL_RESET, pbr_pkg::CTL_RESET}};
    end else begin
      state_reg <= state_next;
    end
  end

  assign mii_rdata = state_reg.rdata;
  assign mii_rvalid = state_reg.rvalid;
  assign sw_view = state_reg.sw_view;
  assign port_ctl = state_reg.ctl;
  // [1]=data steer active, [0]=transmit from port-2 pair kept on normal pins
  assign p1_tx_from_p2_rx = {state_reg.loop_p1_path, 1'b0};
  assign p2_tx_from_p1_rx = {state_reg.loop_p2_path, 1'b0};
endmodule : pbr_regs

/* sim/pbr_station.sv */
// pbr_station: management station model issuing single-cycle read and write requests.
// assumes requests change at the falling edge and the answer follows one cycle later.
`timescale 1ns/100ps
module pbr_station (
  input wire logic clk_sys,
  output logic mii_rd,
  output logic mii_wr,
  output logic [4:0] mii_phyad,
  output logic [4:0] mii_regad,
  output logic [15:0] mii_wdata,
  input wire logic [15:0] mii_rdata,
  input wire logic mii_rvalid
);
  initial begin
    mii_rd = 1'b0;
    mii_wr = 1'b0;
    mii_phyad = 5'h00;
    mii_regad = 5'h00;
    mii_wdata = 16'h0000;
  end

  // gap adds idle cycles for a slow station; zero still leaves one idle cycle between requests
  task automatic xfer(input logic wr, input logic [4:0] phyad, input logic [4:0] regad,
    input logic [15:0] data, input int gap, output logic [15:0] rdata, output logic ok);
    repeat (gap + 1) @(negedge clk_sys);
    mii_wr = wr;
    mii_rd = !wr;
    mii_phyad = phyad;
    mii_regad = regad;
    mii_wdata = data;
    @(negedge clk_sys);
    mii_wr = 1'b0;
    mii_rd = 1'b0;
    mii_wdata = ~data; // stale data must not look valid
    ok = wr || mii_rvalid;
    rdata = mii_rdata;
  endtask : xfer
endmodule : pbr_station

/* sim/pbr_regs_sva.sv */
// pbr_regs_chk: port assertions for pbr_regs.
// assumes one clock; index 0 of per-port vectors is port 1.
`timescale 1ns/100ps
module pbr_regs_chk #(
  parameter logic [4:0] PHYAD_PORT1 = 5'h01,
  parameter logic [4:0] PHYAD_PORT2 = 5'h02
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic phyad_prog_en,
  input wire logic mii_rd,
  input wire logic mii_wr,
  input wire logic [4:0] mii_phyad,
  input wire logic [4:0] mii_regad,
  input wire logic [15:0] mii_wdata,
  input wire logic [15:0] mii_rdata,
  input wire logic mii_rvalid,
  input wire logic [1:0] sw_wr_a,
  input wire logic [1:0] sw_wr_b,
  input wire pbr_pkg::pbr_sw_view_type [1:0] sw_view,
  input wire pbr_pkg::pbr_ctl_type [1:0] port_ctl,
  input wire logic [1:0] p1_tx_from_p2_rx,
  input wire logic [1:0] p2_tx_from_p1_rx
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  logic sts_q;
  logic ctl_q;
  logic miss_q;
  // decode held one cycle so it lines up with the answer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sts_q <= 1'b0;
      ctl_q <= 1'b0;
      miss_q <= 1'b0;
    end else begin
      sts_q <= mii_rd && !phyad_prog_en && mii_regad == 5'h01
        && (mii_phyad == PHYAD_PORT1 || mii_phyad == PHYAD_PORT2);
      ctl_q <= mii_rd && mii_regad == 5'h00;
      miss_q <= mii_rd && ((!phyad_prog_en && mii_phyad != PHYAD_PORT1
        && mii_phyad != PHYAD_PORT2) || mii_regad > 5'h01);
    end
  end
  property p_rvalid; mii_rd |=> mii_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_hold; !mii_rvalid |-> $stable(mii_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_cap; sts_q && mii_rvalid |-> mii_rdata[14:11] == 4'hF; endproperty
  a_cap: assert property (p_cap) else $error("capability bits wrong");
  property p_edge; sts_q && mii_rvalid |-> !mii_rdata[15] && !mii_rdata[0]; endproperty
  a_edge: assert property (p_edge) else $error("status 15 or 0 set");
  property p_rsvd; sts_q && mii_rvalid |-> mii_rdata[10:6] == 5'h00 && !mii_rdata[1]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status set");
  property p_unsup; ctl_q && mii_rvalid |-> (mii_rdata & 16'h84C0) == 16'h0000; endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported control set");
  property p_miss; miss_q && mii_rvalid |-> mii_rdata == 16'h0000; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read not zero");
  property p_mirror;
    mii_wr && !phyad_prog_en && mii_phyad == PHYAD_PORT1 && mii_regad == 5'h00
      && sw_wr_a[0] == 1'b0 && sw_wr_b[0] == 1'b0
      ##1 !mii_wr && sw_wr_a[0] == 1'b0 && sw_wr_b[0] == 1'b0
    |=> sw_view[0].ctl_a[6] == $past(mii_wdata[13], 2)
      && sw_view[0].ctl_b[0] == $past(mii_wdata[14], 2);
  endproperty
  a_mirror: assert property (p_mirror) else $error("switch view not mirrored");
  // steer flop and control flop load on the same edge, so they must agree every cycle
  property p_lb1;
    !p1_tx_from_p2_rx[0]
      && p1_tx_from_p2_rx[1] == (port_ctl[0].loopback && !port_ctl[0].power_down);
  endproperty
  a_lb1: assert property (p_lb1) else $error("port 1 loop wrong");
  property p_lb2;
    !p2_tx_from_p1_rx[0]
      && p2_tx_from_p1_rx[1] == (port_ctl[1].loopback && !port_ctl[1].power_down);
  endproperty
  a_lb2: assert property (p_lb2) else $error("port 2 loop wrong");
endmodule : pbr_regs_chk

bind pbr_regs pbr_regs_chk #(.PHYAD_PORT1(PHYAD_PORT1), .PHYAD_PORT2(PHYAD_PORT2)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .phyad_prog_en(phyad_prog_en), .mii_rd(mii_rd),
  .mii_wr(mii_wr), .mii_phyad(mii_phyad), .mii_regad(mii_regad), .mii_wdata(mii_wdata),
  .mii_rdata(mii_rdata), .mii_rvalid(mii_rvalid), .sw_wr_a(sw_wr_a), .sw_wr_b(sw_wr_b),
  .sw_view(sw_view), .port_ctl(port_ctl), .p1_tx_from_p2_rx(p1_tx_from_p2_rx),
  .p2_tx_from_p1_rx(p2_tx_from_p1_rx));

/* sim/phy_basic_control_status_regs_tb.sv */
// phy_basic_control_status_regs_tb: self-checking bench for pbr_regs.
// assumes pbr_station on the management side; bench drives switch side and status.
`timescale 1ns/100ps
module phy_basic_control_status_regs_tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic phyad_prog_en = 1'b0;
  logic [4:0] phyad_prog = 5'h00;
  logic mii_rd, mii_wr, mii_rvalid, rd_ok;
  logic [4:0] mii_phyad, mii_regad;
  logic [15:0] mii_wdata, mii_rdata, rd_data;
  logic [1:0] sw_wr_a = 2'h0, sw_wr_b = 2'h0, sw_wr_c = 2'h0;
  logic [7:0] sw_wdata = 8'h00;
  pbr_pkg::pbr_sw_view_type [1:0] sw_view;
  pbr_pkg::pbr_phy_sts_type [1:0] phy_sts_async = '0;
  pbr_pkg::pbr_ctl_type [1:0] port_ctl;
  logic [1:0] p1_tx_from_p2_rx, p2_tx_from_p1_rx;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;

  always #4 clk_sys = ~clk_sys;

  pbr_regs dut (.clk_sys(clk_sys), .rstn(rstn), .phyad_prog_en(phyad_prog_en),
    .phyad_prog(phyad_prog), .mii_rd(mii_rd), .mii_wr(mii_wr), .mii_phyad(mii_phyad),
    .mii_regad(mii_regad), .mii_wdata(mii_wdata), .mii_rdata(mii_rdata),
    .mii_rvalid(mii_rvalid), .sw_wr_a(sw_wr_a), .sw_wr_b(sw_wr_b), .sw_wr_c(sw_wr_c),
    .sw_wdata(sw_wdata), .sw_view(sw_view), .phy_sts_async(phy_sts_async),
    .port_ctl(port_ctl), .p1_tx_from_p2_rx(p1_tx_from_p2_rx),
    .p2_tx_from_p1_rx(p2_tx_from_p1_rx));
  pbr_station station (.clk_sys(clk_sys), .mii_rd(mii_rd), .mii_wr(mii_wr),
    .mii_phyad(mii_phyad), .mii_regad(mii_regad), .mii_wdata(mii_wdata),
    .mii_rdata(mii_rdata), .mii_rvalid(mii_rvalid));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [4:0] phyad, input logic [4:0] regad, input logic [15:0] exp);
    station.xfer(1'b0, phyad, regad, 16'h0000, 0, rd_data, rd_ok);
    chk({31'h0, rd_ok}, 32'h1);
    chk({16'h0, rd_data}, {16'h0, exp});
  endtask : rd

  task automatic wr(input logic [4:0] phyad, input logic [4:0] regad, input logic [15:0] d,
    input int gap);
    station.xfer(1'b1, phyad, regad, d, gap, rd_data, rd_ok);
  endtask : wr

  // one-cycle switch-side strobe, then let storage and views settle
  task automatic swr(input logic [1:0] a, input logic [1:0] b, input logic [1:0] c,
    input logic [7:0] d);
    @(negedge clk_sys);
    {sw_wr_a, sw_wr_b, sw_wr_c, sw_wdata} = {a, b, c, d};
    @(negedge clk_sys);
    {sw_wr_a, sw_wr_b, sw_wr_c, sw_wdata} = {6'h00, ~d};
    repeat (2) @(negedge clk_sys);
  endtask : swr

  task automatic t_reset;
    rd(5'h01, 5'h00, 16'h1020);
    rd(5'h02, 5'h00, 16'h1020);
    rd(5'h01, 5'h01, 16'h7808);
    chk({20'h00000, port_ctl[0]}, {20'h00000, pbr_pkg::CTL_RESET});
  endtask : t_reset

  task automatic t_mgmt_write;
    wr(5'h01, 5'h00, 16'hFFFF, 0);
    rd(5'h01, 5'h00, 16'h7B3F);
    chk({24'h000000, sw_view[0].ctl_b}, 32'h000000FF);
    chk({29'h00000000, sw_view[0].ctl_a[7:5]}, 32'h00000007);
    chk({31'h00000000, sw_view[0].sts_c[7]}, 32'h00000001);
    chk({31'h00000000, port_ctl[0].disable_led}, 32'h00000001);
    chk({30'h00000000, p1_tx_from_p2_rx}, 32'h00000000);
    wr(5'h01, 5'h00, 16'h4000, 3);
    rd(5'h01, 5'h01, 16'h7800);
    chk({30'h00000000, p1_tx_from_p2_rx}, 32'h00000002);
    chk({30'h00000000, p2_tx_from_p1_rx}, 32'h00000000);
    rd(5'h02, 5'h00, 16'h1020);
  endtask : t_mgmt_write

  task automatic t_switch_write;
    swr(2'h0, 2'h2, 2'h0, 8'h01);
    chk({30'h00000000, p2_tx_from_p1_rx}, 32'h00000002);
    rd(5'h02, 5'h00, 16'h5020);
    swr(2'h2, 2'h0, 2'h0, 8'h60);
    rd(5'h02, 5'h00, 16'h6120);
    swr(2'h0, 2'h0, 2'h2, 8'h00);
    rd(5'h02, 5'h00, 16'h6100);
    wr(5'h02, 5'h00, 16'h0000, 0);
    rd(5'h02, 5'h00, 16'h0000);
    chk({24'h000000, sw_view[1].ctl_b}, 32'h00000000);
    chk({30'h00000000, p2_tx_from_p1_rx}, 32'h00000000);
  endtask : t_switch_write

  task automatic t_status;
    @(negedge clk_sys);
    phy_sts_async[0] = 3'h7;
    repeat (4) @(negedge clk_sys);
    rd(5'h01, 5'h01, 16'h7834);
    chk({24'h000000, sw_view[0].sts_c}, 32'h00000061);
    phy_sts_async[0] = 3'h1;
    repeat (4) @(negedge clk_sys);
    rd(5'h01, 5'h01, 16'h7804);
    phy_sts_async[0] = 3'h0;
  endtask : t_status

  task automatic t_refused;
    wr(5'h01, 5'h01, 16'h0000, 0);
    rd(5'h01, 5'h01, 16'h7800);
    wr(5'h03, 5'h00, 16'hFFFF, 0);
    rd(5'h03, 5'h00, 16'h0000);
    rd(5'h01, 5'h02, 16'h0000);
    rd(5'h01, 5'h00, 16'h4000);
  endtask : t_refused

  task automatic t_prog_addr;
    @(negedge clk_sys);
    {phyad_prog_en, phyad_prog} = {1'b1, 5'h08};
    rd(5'h08, 5'h00, 16'h4000);
    rd(5'h09, 5'h01, 16'h7800);
    rd(5'h01, 5'h00, 16'h0000);
    phyad_prog_en = 1'b0;
  endtask : t_prog_addr

  // management and switch-side writes to port 1 taken on the same edge; switch side wins
  task automatic t_tie;
    fork
      wr(5'h01, 5'h00, 16'h0000, 0);
      swr(2'h1, 2'h0, 2'h0, 8'h40);
    join
    rd(5'h01, 5'h00, 16'h2000);
    chk({24'h000000, sw_view[0].ctl_a}, 32'h00000040);
  endtask : t_tie

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    t_reset();
    t_mgmt_write();
    t_switch_write();
    t_status();
    t_refused();
    t_prog_addr();
    t_tie();
    @(negedge clk_sys);
    rstn = 1'b0;
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    t_reset();
    end_of_test();
  end
endmodule : phy_basic_control_status_regs_tb
